// file: hw/rwerp_pkg.sv
package rwerp_pkg;

  // Page byte offsets
  localparam logic [3:0] RWERP_OFS_HDR    = 4'h0;
  localparam logic [3:0] RWERP_OFS_LEN    = 4'h1;
  localparam logic [3:0] RWERP_OFS_FLAGS  = 4'h2;
  localparam logic [3:0] RWERP_OFS_RRETRY = 4'h3;
  localparam logic [3:0] RWERP_OFS_WRETRY = 4'h8;
  localparam logic [3:0] RWERP_OFS_TLIM_H = 4'hA;
  localparam logic [3:0] RWERP_OFS_TLIM_L = 4'hB;

  // Flag byte bit positions, plus the PS bit of the header byte
  localparam int RWERP_BIT_WR_REALLOC = 7;
  localparam int RWERP_BIT_RD_REALLOC = 6;
  localparam int RWERP_BIT_XFER_UNREC = 5;
  localparam int RWERP_BIT_CONT_READ  = 4;
  localparam int RWERP_BIT_POST_ERR   = 2;
  localparam int RWERP_BIT_TERM_ERR   = 1;
  localparam int RWERP_BIT_PS         = 7;

  // Fixed and reset values
  localparam logic [5:0]  RWERP_PAGE_CODE   = 6'h01;
  localparam logic [7:0]  RWERP_PAGE_LEN    = 8'h0A;
  localparam logic [7:0]  RWERP_FLAGS_RST   = 8'hC0;
  localparam logic [7:0]  RWERP_FLAGS_WMASK = 8'hF6;
  localparam logic [7:0]  RWERP_RRETRY_RST  = 8'h01;
  localparam logic [7:0]  RWERP_WRETRY_RST  = 8'h01;
  localparam logic [15:0] RWERP_TLIM_RST    = 16'h0000;
  localparam logic [7:0]  RWERP_DEF_PASSES  = 8'h10;

  // Timing
  localparam int          RWERP_CLK_HZ      = 125000000;
  localparam int          RWERP_TICK_MS     = 50;
  localparam int          RWERP_TICK_CYCLES = RWERP_CLK_HZ / 1000 * RWERP_TICK_MS;
  localparam logic [16:0] RWERP_TICK_STEP   = 17'(RWERP_TICK_MS);

  // Sense keys
  localparam logic [3:0] RWERP_SENSE_NONE = 4'h0;
  localparam logic [3:0] RWERP_SENSE_RCVD = 4'h1;
  localparam logic [3:0] RWERP_SENSE_MED  = 4'h3;

  typedef enum logic [1:0] {
    RWERP_RES_OK   = 2'b00,
    RWERP_RES_RCVD = 2'b01,
    RWERP_RES_FAIL = 2'b10
  } rwerp_result_type;

  typedef enum logic [1:0] {
    RWERP_ST_IDLE  = 2'b00,
    RWERP_ST_XFER  = 2'b01,
    RWERP_ST_RECOV = 2'b10,
    RWERP_ST_STAT  = 2'b11
  } rwerp_state_type;

endpackage : rwerp_pkg

// file: hw/rwerp_page_regs.sv
`timescale 1ns/1ps
module rwerp_page_regs import rwerp_pkg::*; #(
  parameter logic PS_VALUE = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic             wr_ack,
  output logic      [7:0]  flags,
  output logic      [7:0]  rd_retry,
  output logic      [7:0]  wr_retry,
  output logic      [15:0] time_limit
);

  logic [7:0]  flags_ff;
  logic [7:0]  rretry_ff;
  logic [7:0]  wretry_ff;
  logic [15:0] tlim_ff;
  logic [7:0]  rdata_ff;
  logic        ack_ff;
  logic [7:0]  nxt_rdata;

  // Read-only and reserved bytes take the write silently
  always_ff @(posedge clock) begin
    if (reset) begin
      flags_ff  <= RWERP_FLAGS_RST;
      rretry_ff <= RWERP_RRETRY_RST;
      wretry_ff <= RWERP_WRETRY_RST;
      tlim_ff   <= RWERP_TLIM_RST;
    end else if (wr) begin
      case (addr)
        RWERP_OFS_FLAGS:  flags_ff      <= wdata & RWERP_FLAGS_WMASK;
        RWERP_OFS_RRETRY: rretry_ff     <= wdata;
        RWERP_OFS_WRETRY: wretry_ff     <= wdata;
        RWERP_OFS_TLIM_H: tlim_ff[15:8] <= wdata;
        RWERP_OFS_TLIM_L: tlim_ff[7:0]  <= wdata;
        default: ;
      endcase
    end
  end

  // Every byte write completes, legal flag mix or not
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wr;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    case (addr)
      RWERP_OFS_HDR:    nxt_rdata = {PS_VALUE, 1'b0, RWERP_PAGE_CODE};
      RWERP_OFS_LEN:    nxt_rdata = RWERP_PAGE_LEN;
      RWERP_OFS_FLAGS:  nxt_rdata = flags_ff;
      RWERP_OFS_RRETRY: nxt_rdata = rretry_ff;
      RWERP_OFS_WRETRY: nxt_rdata = wretry_ff;
      RWERP_OFS_TLIM_H: nxt_rdata = tlim_ff[15:8];
      RWERP_OFS_TLIM_L: nxt_rdata = tlim_ff[7:0];
      default:          nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata      = rdata_ff;
  assign wr_ack     = ack_ff;
  assign flags      = flags_ff;
  assign rd_retry   = rretry_ff;
  assign wr_retry   = wretry_ff;
  assign time_limit = tlim_ff;

endmodule : rwerp_page_regs

// file: hw/rwerp_recov_timer.sv
`timescale 1ns/1ps
module rwerp_recov_timer import rwerp_pkg::*; #(
  parameter int TICK_CYCLES = RWERP_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        run,
  input  wire logic [15:0] limit_ms,
  output logic             expired
);

  localparam int DW = $clog2(TICK_CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

  logic [DW-1:0] div_ff;
  logic          tick;
  logic [16:0]   elapsed_ff;
  logic          expired_ff;

  assign tick = run && (div_ff == DIV_LAST);

  // Divider restarts with each recovery, so every block gets a fresh budget
  always_ff @(posedge clock) begin
    if (reset || !run || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // Coarse step: expiry only seen on a tick boundary
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      elapsed_ff <= '0;
    end else if (tick && !elapsed_ff[16]) begin
      elapsed_ff <= elapsed_ff + RWERP_TICK_STEP;
    end
  end

  // Zero limit never expires
  always_ff @(posedge clock) begin
    if (reset) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= run && (limit_ms != 16'h0000) && (elapsed_ff >= {1'b0, limit_ms});
    end
  end

  assign expired = expired_ff;

endmodule : rwerp_recov_timer

// file: hw/rwerp_policy.sv
// Overview of operation
// - Write reallocation flag set: defective blocks reallocated during writes.
// - Read reallocation flag set: defective blocks reallocated during reads.
// - Transfer-unrecovered set: failing block sent before check condition; else withheld.
// - Blocks recovered within limits are always transferred.
// - Continuous read delivers full length without recovery pauses, pseudo data allowed.
// - Continuous read overrides post-error, terminate, correction and transfer flags.
// - Continuous read applies to read commands only.
// - Continuous read disables data-field detection; servo errors still recovered.
// - Post-error set: recovered errors reported to the initiator.
// - Terminate-on-error set: transfer halts at first recovered error.
// - Read retry count limits read recovery passes; zero disables read recovery.
// - AV retry mode off: any nonzero count enables all steps; on: count is maximum.
// - Write retry count limits write recovery passes; zero disables write recovery.
// - Recovery time limit in 1 ms units, host programs 40 to 65535.
// - Timer steps 50 ms; unrecovered within limit gives check condition.
// - Time limit ignored for writes with write cache on; zero disables timer.
// - Illegal flag mix accepted silently; later error behaviour undefined.
// - Post-error and terminate clear: retries, recovered data sent, no final check.
// - All three clear: soft errors do not end transfer; full length sent.
// - All three clear: hard error stops, block withheld, check condition follows.
// - Only transfer-unrecovered set: hard error stops after block sent, then check.
`timescale 1ns/1ps
module rwerp_policy import rwerp_pkg::*; #(
  parameter int         TICK_CYCLES = RWERP_TICK_CYCLES,
  parameter logic [7:0] DEF_PASSES  = RWERP_DEF_PASSES,
  parameter logic       PS_VALUE    = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        page_wr,
  input  wire logic        page_rd,
  input  wire logic [3:0]  page_addr,
  input  wire logic [7:0]  page_wdata,
  output logic      [7:0]  page_rdata,
  output logic             page_wr_ack,
  input  wire logic        write_cache_enable,
  input  wire logic        av_retry_mode,
  input  wire logic        cmd_start,
  input  wire logic        cmd_read,
  input  wire logic [31:0] cmd_lba,
  input  wire logic [15:0] cmd_blocks,
  input  wire logic        blk_done,
  input  wire logic [1:0]  blk_result,
  input  wire logic        blk_servo,
  output logic             blk_send,
  output logic             blk_pseudo,
  output logic             realloc_req,
  output logic             pass_grant,
  output logic             data_detect_en,
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic             check_cond,
  output logic      [3:0]  sense_key,
  output logic      [31:0] sense_info
);

  logic [7:0]      flags;
  logic [7:0]      rd_retry;
  logic [7:0]      wr_retry;
  logic [15:0]     time_limit;
  logic            expired;

  rwerp_state_type state_ff;
  rwerp_state_type nxt_state;
  logic            is_read_ff;
  logic [15:0]     remain_ff;
  logic [31:0]     lba_ff;
  logic [7:0]      passes_ff;
  logic            soft_seen_ff;
  logic [31:0]     soft_lba_ff;

  logic            send_ff;
  logic            pseudo_ff;
  logic            realloc_ff;
  logic            grant_ff;
  logic            detect_ff;
  logic            busy_ff;
  logic            done_ff;
  logic            check_ff;
  logic [3:0]      sense_ff;
  logic [31:0]     info_ff;

  logic            rc_eff;
  logic            per_eff;
  logic            dte_eff;
  logic            tb_eff;
  logic [7:0]      retry_lim;
  logic [7:0]      max_passes;
  logic            realloc_en;
  logic            timer_run;
  logic            last_blk;
  logic            in_xfer;
  logic            in_recov;
  logic            ok_evt;
  logic            soft_evt;
  logic            hard_evt;
  logic            pseudo_evt;
  logic            retry_evt;
  logic            adv_evt;
  logic            stop_evt;
  logic            end_evt;
  logic            accept;

  // Continuous read only ever applies to reads
  function automatic logic cont_read_on(input logic [7:0] flg, input logic rd_cmd);
    return flg[RWERP_BIT_CONT_READ] && rd_cmd;
  endfunction : cont_read_on

  rwerp_page_regs #(
    .PS_VALUE (PS_VALUE)
  ) u_page (
    .clock      (clock),
    .reset      (reset),
    .wr         (page_wr),
    .rd         (page_rd),
    .addr       (page_addr),
    .wdata      (page_wdata),
    .rdata      (page_rdata),
    .wr_ack     (page_wr_ack),
    .flags      (flags),
    .rd_retry   (rd_retry),
    .wr_retry   (wr_retry),
    .time_limit (time_limit)
  );

  rwerp_recov_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock    (clock),
    .reset    (reset),
    .run      (timer_run),
    .limit_ms (time_limit),
    .expired  (expired)
  );

  // Effective policy for the command in flight
  always_comb begin
    rc_eff     = cont_read_on(flags, is_read_ff);
    per_eff    = flags[RWERP_BIT_POST_ERR] && !rc_eff;
    dte_eff    = flags[RWERP_BIT_TERM_ERR] && !rc_eff;
    tb_eff     = flags[RWERP_BIT_XFER_UNREC] && !rc_eff;
    retry_lim  = is_read_ff ? rd_retry : wr_retry;
    max_passes = (is_read_ff && !av_retry_mode) ? DEF_PASSES : retry_lim;
    realloc_en = is_read_ff ? flags[RWERP_BIT_RD_REALLOC]
                            : flags[RWERP_BIT_WR_REALLOC];
    timer_run  = (state_ff == RWERP_ST_RECOV) && !(!is_read_ff && write_cache_enable);
    last_blk   = (remain_ff == 16'h0001);
    in_xfer    = (state_ff == RWERP_ST_XFER);
    in_recov   = (state_ff == RWERP_ST_RECOV);
    accept     = (state_ff == RWERP_ST_IDLE) && cmd_start;
  end

  // Classify each block outcome
  always_comb begin
    ok_evt     = 1'b0;
    soft_evt   = 1'b0;
    hard_evt   = 1'b0;
    pseudo_evt = 1'b0;
    retry_evt  = 1'b0;
    if (in_xfer && blk_done) begin
      case (blk_result)
        RWERP_RES_OK:   ok_evt = 1'b1;
        RWERP_RES_RCVD: soft_evt = 1'b1;
        RWERP_RES_FAIL: begin
          if (rc_eff && !blk_servo) begin
            pseudo_evt = 1'b1;
          end else if (retry_lim == 8'h00) begin
            hard_evt = 1'b1;
          end else begin
            retry_evt = 1'b1;
          end
        end
        default:        hard_evt = 1'b1;
      endcase
    end else if (in_recov && blk_done) begin
      if (blk_result == RWERP_RES_OK || blk_result == RWERP_RES_RCVD) begin
        soft_evt = 1'b1;
      end else if (passes_ff >= max_passes) begin
        hard_evt = 1'b1;
      end else begin
        retry_evt = 1'b1;
      end
    end else if (in_recov && expired) begin
      hard_evt = 1'b1;
    end
    adv_evt  = ok_evt || soft_evt || pseudo_evt;
    stop_evt = hard_evt || (soft_evt && dte_eff);
    end_evt  = stop_evt || (adv_evt && last_blk);
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RWERP_ST_IDLE: begin
        if (cmd_start) begin
          nxt_state = (cmd_blocks == 16'h0000) ? RWERP_ST_STAT : RWERP_ST_XFER;
        end
      end
      RWERP_ST_XFER: begin
        if (end_evt) begin
          nxt_state = RWERP_ST_STAT;
        end else if (retry_evt) begin
          nxt_state = RWERP_ST_RECOV;
        end
      end
      RWERP_ST_RECOV: begin
        if (end_evt) begin
          nxt_state = RWERP_ST_STAT;
        end else if (soft_evt) begin
          nxt_state = RWERP_ST_XFER;
        end
      end
      RWERP_ST_STAT: nxt_state = RWERP_ST_IDLE;
      default:       nxt_state = RWERP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= RWERP_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command context
  always_ff @(posedge clock) begin
    if (reset) begin
      is_read_ff <= 1'b0;
      remain_ff  <= 16'h0000;
      lba_ff     <= 32'h0000_0000;
    end else if (accept) begin
      is_read_ff <= cmd_read;
      remain_ff  <= cmd_blocks;
      lba_ff     <= cmd_lba;
    end else if (adv_evt) begin
      remain_ff  <= remain_ff - 16'h0001;
      lba_ff     <= lba_ff + 32'h0000_0001;
    end
  end

  // Recovery passes granted for the current block
  always_ff @(posedge clock) begin
    if (reset) begin
      passes_ff <= 8'h00;
    end else if (in_xfer && retry_evt) begin
      passes_ff <= 8'h01;
    end else if (retry_evt && passes_ff != 8'hFF) begin
      passes_ff <= passes_ff + 8'h01;
    end
  end

  // Last recovered block, for the deferred report
  always_ff @(posedge clock) begin
    if (reset) begin
      soft_seen_ff <= 1'b0;
      soft_lba_ff  <= 32'h0000_0000;
    end else if (accept) begin
      soft_seen_ff <= 1'b0;
    end else if (soft_evt) begin
      soft_seen_ff <= 1'b1;
      soft_lba_ff  <= lba_ff;
    end
  end

  // Per-block strobes toward the transfer engine
  always_ff @(posedge clock) begin
    if (reset) begin
      send_ff    <= 1'b0;
      pseudo_ff  <= 1'b0;
      realloc_ff <= 1'b0;
      grant_ff   <= 1'b0;
    end else begin
      send_ff    <= adv_evt || (hard_evt && tb_eff);
      pseudo_ff  <= pseudo_evt;
      realloc_ff <= soft_evt && realloc_en;
      grant_ff   <= retry_evt;
    end
  end

  // Data-field checking off for the whole continuous read, status cycle
  // included; taken from the incoming command so no stale mode leaks in
  always_ff @(posedge clock) begin
    if (reset) begin
      detect_ff <= 1'b1;
    end else if (accept) begin
      detect_ff <= !(cont_read_on(flags, cmd_read) && (cmd_blocks != 16'h0000));
    end else begin
      detect_ff <= !((nxt_state != RWERP_ST_IDLE) && rc_eff);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      busy_ff   <= (nxt_state != RWERP_ST_IDLE);
      done_ff   <= (state_ff == RWERP_ST_STAT);
    end
  end

  // Final status, held until the next command; mixing terminate without
  // post-error is not trapped, the bits are simply obeyed
  always_ff @(posedge clock) begin
    if (reset) begin
      check_ff <= 1'b0;
      sense_ff <= RWERP_SENSE_NONE;
      info_ff  <= 32'h0000_0000;
    end else if (accept) begin
      check_ff <= 1'b0;
      sense_ff <= RWERP_SENSE_NONE;
      info_ff  <= 32'h0000_0000;
    end else if (hard_evt) begin
      check_ff <= 1'b1;
      sense_ff <= RWERP_SENSE_MED;
      info_ff  <= lba_ff;
    end else if (soft_evt && dte_eff) begin
      check_ff <= 1'b1;
      sense_ff <= RWERP_SENSE_RCVD;
      info_ff  <= lba_ff;
    end else if (adv_evt && last_blk && per_eff && (soft_seen_ff || soft_evt)) begin
      check_ff <= 1'b1;
      sense_ff <= RWERP_SENSE_RCVD;
      info_ff  <= soft_evt ? lba_ff : soft_lba_ff;
    end
  end

  assign blk_send       = send_ff;
  assign blk_pseudo     = pseudo_ff;
  assign realloc_req    = realloc_ff;
  assign pass_grant     = grant_ff;
  assign data_detect_en = detect_ff;
  assign cmd_busy       = busy_ff;
  assign cmd_done       = done_ff;
  assign check_cond     = check_ff;
  assign sense_key      = sense_ff;
  assign sense_info     = info_ff;

endmodule : rwerp_policy

// file: verif/rwerp_policy_sva.sv
`timescale 1ns/1ps
module rwerp_policy_sva import rwerp_pkg::*; (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       page_wr,
  input wire logic       page_wr_ack,
  input wire logic       cmd_start,
  input wire logic       cmd_busy,
  input wire logic       cmd_done,
  input wire logic       blk_done,
  input wire logic [1:0] blk_result,
  input wire logic       blk_send,
  input wire logic       blk_pseudo,
  input wire logic       realloc_req,
  input wire logic       pass_grant,
  input wire logic       data_detect_en,
  input wire logic       check_cond,
  input wire logic [3:0] sense_key
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_ack; page_wr |=> page_wr_ack; endproperty
  a_ack: assert property (p_ack) else $error("page write not acknowledged");
  property p_no_ack; !page_wr |=> !page_wr_ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray write ack");
  property p_start; cmd_start && !cmd_busy |=> cmd_busy ##1 (cmd_busy || cmd_done); endproperty
  a_start: assert property (p_start) else $error("command not taken");
  property p_kept; blk_done && cmd_busy && blk_result != RWERP_RES_FAIL |=> blk_send; endproperty
  a_kept: assert property (p_kept) else $error("good block not sent");
  property p_pseudo; blk_pseudo |-> blk_send && !data_detect_en; endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo block misframed");
  property p_realloc; realloc_req |-> blk_send; endproperty
  a_realloc: assert property (p_realloc) else $error("realloc without send");
  property p_grant; pass_grant |-> !blk_send && !cmd_done; endproperty
  a_grant: assert property (p_grant) else $error("grant with send");
  property p_done; cmd_done |=> !cmd_busy; endproperty
  a_done: assert property (p_done) else $error("busy after done");
  property p_hold; !cmd_busy && !cmd_start |=> $stable(check_cond) && $stable(sense_key); endproperty
  a_hold: assert property (p_hold) else $error("status changed while idle");
endmodule : rwerp_policy_sva

// file: verif/rwerp_media_model.sv
`timescale 1ns/1ps
module rwerp_media_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        cmd_busy,
  input  wire logic        cmd_done,
  input  wire logic        blk_send,
  input  wire logic        pass_grant,
  input  wire logic [15:0] script,
  input  wire logic [7:0]  servo_mask,
  input  wire logic [7:0]  gap,
  output logic             blk_done,
  output logic      [1:0]  blk_result,
  output logic             blk_servo
);
  logic       busy_q_ff;
  logic [7:0] wait_ff;
  logic [2:0] idx_ff;
  // Result lines toggle when idle so a stale value is never trusted
  always_ff @(posedge clock) begin
    busy_q_ff  <= cmd_busy;
    blk_done   <= 1'b0;
    blk_result <= reset ? 2'h0 : ~blk_result;
    blk_servo  <= reset ? 1'b0 : ~blk_servo;
    if (reset || !cmd_busy) begin
      idx_ff <= 3'h0;
    end
    if (reset || !cmd_busy || cmd_done) begin
      wait_ff <= 8'h00;
    end else if ((cmd_busy && !busy_q_ff) || blk_send || pass_grant) begin
      wait_ff <= gap + 8'h02;
    end else if (wait_ff == 8'h01) begin
      wait_ff    <= 8'h00;
      blk_done   <= 1'b1;
      blk_result <= script[2*idx_ff+:2];
      blk_servo  <= servo_mask[idx_ff];
      idx_ff     <= idx_ff + 3'h1;
    end else if (wait_ff != 8'h00) begin
      wait_ff <= wait_ff - 8'h01;
    end
  end
endmodule : rwerp_media_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb_top import rwerp_pkg::*;;
  logic clock = 1'b0, reset = 1'b1, page_wr = 1'b0, page_rd = 1'b0, write_cache_enable = 1'b0;
  logic av_retry_mode = 1'b0, cmd_start = 1'b0, cmd_read = 1'b0;
  logic [3:0]  page_addr = 4'h0;
  logic [7:0]  page_wdata = 8'h00, servo_mask = 8'h00, gap = 8'h00, page_rdata;
  logic [31:0] cmd_lba = 32'h0, sense_info;
  logic [15:0] cmd_blocks = 16'h0, script = 16'h0;
  logic        blk_done, blk_servo, blk_send, blk_pseudo, realloc_req, pass_grant, data_detect_en;
  logic        page_wr_ack, cmd_busy, cmd_done, check_cond;
  logic [1:0]  blk_result;
  logic [3:0]  sense_key;
  logic [7:0]  sh [16];
  integer      seed = 72;
  int          fail_count = 0, check_count = 0, n_send = 0, n_rl = 0, n_ps = 0;
  localparam logic PS_VALUE_TB = 1'b0;
  always #4 clock = ~clock;
  rwerp_policy #(.TICK_CYCLES(10)) rwerp_policy_inst (.clock(clock), .reset(reset), .page_wr(page_wr),
    .page_rd(page_rd), .page_addr(page_addr), .page_wdata(page_wdata), .page_rdata(page_rdata),
    .page_wr_ack(page_wr_ack), .write_cache_enable(write_cache_enable), .av_retry_mode(av_retry_mode),
    .cmd_start(cmd_start), .cmd_read(cmd_read), .cmd_lba(cmd_lba), .cmd_blocks(cmd_blocks),
    .blk_done(blk_done), .blk_result(blk_result), .blk_servo(blk_servo), .blk_send(blk_send),
    .blk_pseudo(blk_pseudo), .realloc_req(realloc_req), .pass_grant(pass_grant),
    .data_detect_en(data_detect_en), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .check_cond(check_cond),
    .sense_key(sense_key), .sense_info(sense_info));
  rwerp_media_model rwerp_media_model_inst (.clock(clock), .reset(reset), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .blk_send(blk_send), .pass_grant(pass_grant), .script(script),
    .servo_mask(servo_mask), .gap(gap), .blk_done(blk_done), .blk_result(blk_result), .blk_servo(blk_servo));
  always @(posedge clock) begin
    n_send <= cmd_start ? 0 : n_send + (blk_send === 1'b1);
    n_rl   <= cmd_start ? 0 : n_rl + (realloc_req === 1'b1);
    n_ps   <= cmd_start ? 0 : n_ps + (blk_pseudo === 1'b1);
  end
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic pw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    page_wr <= 1'b1;
    page_addr <= a;
    page_wdata <= d;
    @(posedge clock);
    page_wr <= 1'b0;
    if (a inside {4'h2, 4'h3, 4'h8, 4'hA, 4'hB}) sh[a] = (a == 4'h2) ? (d & RWERP_FLAGS_WMASK) : d;
    #1;
    `CHK("page_wr_ack", page_wr_ack, 1'b1)
  endtask : pw
  task automatic pr(input logic [3:0] a);
    @(posedge clock);
    page_rd <= 1'b1;
    page_addr <= a;
    @(posedge clock);
    page_rd <= 1'b0;
    #1;
    `CHK("page_rdata", page_rdata, sh[a])
  endtask : pr
  // Walks the block outcomes; recovery passes are assumed to end recovered unless the timer runs out
  function automatic void exp_run(input logic [7:0] f, input logic rd, input int nb, input logic [15:0] sc,
    input logic [7:0] cnt, input logic tmo, input logic [7:0] srv, output logic cc, output logic [3:0] sk,
    output int snd, output int rl, output int ps, output int lo);
    int i;
    logic [1:0] r;
    logic cr, rec;
    cc = 1'b0; sk = 4'h0; snd = 0; rl = 0; ps = 0; lo = 0; i = 0; rec = 1'b0;
    cr = f[4] && rd;
    for (int b = 0; b < nb && !cc; b++) begin
      r = sc[2*i+:2];
      if (r == 2'h2 && cr && !srv[i]) begin ps++; r = 2'h0; end
      else if (r == 2'h2 && (cnt == 8'h00 || tmo)) begin snd += (f[5] && !cr); cc = 1'b1; sk = 4'h3; lo = b; end
      else if (r == 2'h2) begin i++; r = 2'h1; end
      i++;
      if (r != 2'h2) snd++;
      if (r == 2'h1) begin
        rl += rd ? f[6] : f[7];
        rec = 1'b1;
        lo = b;
        if (f[1] && !cr) begin cc = 1'b1; sk = 4'h1; end
      end
    end
    if (!cc && f[2] && !cr && rec) begin cc = 1'b1; sk = 4'h1; end
  endfunction : exp_run
  task automatic run(input logic [7:0] f, input logic rd, input int nb, input logic [15:0] sc, input logic [7:0] cnt,
    input logic [15:0] tl, input logic [7:0] gp, input logic wc, input logic [7:0] srv);
    logic cc;
    logic [3:0] sk;
    logic [31:0] lba;
    int snd, rl, ps, lo, n;
    pw(RWERP_OFS_FLAGS, f);
    pw(rd ? RWERP_OFS_RRETRY : RWERP_OFS_WRETRY, cnt);
    pw(RWERP_OFS_TLIM_H, tl[15:8]);
    pw(RWERP_OFS_TLIM_L, tl[7:0]);
    exp_run(f, rd, nb, sc, cnt, gp > 8'h14 && tl != 16'h0 && (rd || !wc), srv, cc, sk, snd, rl, ps, lo);
    lba = $random(seed);
    @(posedge clock);
    script <= sc;
    servo_mask <= srv;
    gap <= gp;
    write_cache_enable <= wc;
    av_retry_mode <= 1'($random(seed));
    cmd_start <= 1'b1;
    cmd_read <= rd;
    cmd_blocks <= 16'(nb);
    cmd_lba <= lba;
    @(posedge clock);
    cmd_start <= 1'b0;
    for (n = 0; n < 400 && cmd_done !== 1'b1; n++) begin @(posedge clock); #1; end
    if (n == 400) begin fail_count++; tally_and_finish(); end
    `CHK("check_cond", check_cond, cc)
    `CHK("sense_key", sense_key, sk)
    if (cc) `CHK("sense_info", sense_info, 32'(lba + lo))
    `CHK("sends", n_send, snd)
    `CHK("reallocs", n_rl, rl)
    `CHK("pseudo", n_ps, ps)
  endtask : run
  initial begin
    foreach (sh[k]) sh[k] = 8'h00;
    sh[0] = {PS_VALUE_TB, 1'b0, RWERP_PAGE_CODE};
    sh[1] = RWERP_PAGE_LEN;
    sh[2] = RWERP_FLAGS_RST;
    sh[3] = RWERP_RRETRY_RST;
    sh[8] = RWERP_WRETRY_RST;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (int k = 0; k < 16; k++) pr(4'(k));
    for (int k = 0; k < 20; k++) begin
      pw(4'($random(seed)), 8'($random(seed)));
      pr(4'($random(seed)));
    end
    run(8'hC0, 1'b1, 3, 16'h0004, 8'h01, 16'h0000, 8'h02, 1'b0, 8'h00);
    run(8'h84, 1'b0, 2, 16'h0001, 8'h01, 16'h0000, 8'h00, 1'b0, 8'h00);
    run(8'h06, 1'b1, 3, 16'h0004, 8'h01, 16'h0000, 8'h01, 1'b0, 8'h00);
    run(8'h00, 1'b1, 3, 16'h0008, 8'h00, 16'h0000, 8'h00, 1'b0, 8'h00);
    run(8'h20, 1'b1, 3, 16'h0008, 8'h00, 16'h0000, 8'h03, 1'b0, 8'h00);
    run(8'h32, 1'b1, 3, 16'h0006, 8'h01, 16'h0000, 8'h00, 1'b0, 8'h00);
    run(8'h14, 1'b1, 2, 16'h0009, 8'h01, 16'h0000, 8'h00, 1'b0, 8'h00);
    run(8'h10, 1'b0, 2, 16'h0008, 8'h00, 16'h0000, 8'h00, 1'b0, 8'h00);
    run(8'h10, 1'b1, 2, 16'h0012, 8'h01, 16'h0000, 8'h00, 1'b0, 8'h01);
    run(8'h00, 1'b1, 2, 16'h0012, 8'h01, 16'h0032, 8'h28, 1'b0, 8'h00);
    run(8'h00, 1'b0, 2, 16'h0012, 8'h01, 16'h0032, 8'h28, 1'b1, 8'h00);
    run(8'h00, 1'b1, 2, 16'h0012, 8'h01, 16'h0000, 8'h28, 1'b0, 8'h00);
    run(8'h04, 1'b1, 0, 16'h0000, 8'h01, 16'h0000, 8'h00, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
bind rwerp_policy rwerp_policy_sva rwerp_policy_sva_inst (.clock(clock), .reset(reset), .page_wr(page_wr),
  .page_wr_ack(page_wr_ack), .cmd_start(cmd_start), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
  .blk_done(blk_done), .blk_result(blk_result), .blk_send(blk_send), .blk_pseudo(blk_pseudo),
  .realloc_req(realloc_req), .pass_grant(pass_grant), .data_detect_en(data_detect_en),
  .check_cond(check_cond), .sense_key(sense_key));
